// ===== design/sism_core.sv
// Behaviour
// R1 - Eight event flags: near enter/leave both thresholds, gesture, sample, watchdog, queue; reset zero.
// R2 - Writing one to an event flag clears only that flag; zero leaves it.
// R3 - Reading the event status returns current flags then clears the register.
// R4 - Flag 7 sets when the queue level exceeds the four-bit queue level threshold.
// R5 - Mask bits follow the status bit order; each mask bit gates its own source.
// R6 - Upper status byte reports queue bytes available to read; resets to zero.
// R7 - Writing one to status bit 15 clears count bits 6 to 0, emptying the queue.
// R8 - Read-only sixteen-bit slave status; bit 0 flags address match, may drive interrupt.
// R9 - Mask is active high, resets to all ones, so all sources start masked.
// R10 - Write-one-clear fields are readable and writable; a written one clears, never stores.
// R11 - Interrupt is high while any set flag is unmasked, low once all are cleared and no routed address match is set.
`timescale 1ns/1ns
module sism_core
  import sism_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = 8
)
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Register port from the serial slave engine.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Event sources, one-cycle pulses.
  input wire logic near_enter_first,
  input wire logic near_leave_first,
  input wire logic near_enter_second,
  input wire logic near_leave_second,
  input wire logic gesture_event,
  input wire logic sample_event,
  input wire logic watchdog_event,
  // Queue side.
  input wire logic [COUNT_WIDTH-1:0] queue_level,
  input wire logic [3:0] queue_level_threshold,
  output logic queue_flush,
  // Serial slave engine status and routing.
  input wire logic [15:0] slave_status_in,
  input wire logic addr_match_irq_en,
  // Interrupt output.
  output logic irq
);
  // The count, the comparison and the read word are all built for a byte-wide level.
  if (COUNT_WIDTH != 8)
  begin
    $error("sism_core: COUNT_WIDTH must be 8");
  end

  sism_event_if evt ();

  sism_event_latch sism_event_latch_i
  (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .evt(evt.latch)
  );

  logic [7:0] event_mask;
  logic [7:0] queue_count;
  logic [7:0] level_seen;
  logic [15:0] slave_status;
  logic over_threshold_q;
  logic [15:0] next_rdata;

  wire hit_mask = reg_addr == ADDR_EVENT_MASK;
  wire hit_status = reg_addr == ADDR_EVENT_STATUS;
  wire hit_slave = reg_addr == ADDR_SLAVE_STATUS;
  wire wr_mask = reg_write && hit_mask;
  wire wr_status = reg_write && hit_status;
  wire rd_status = reg_read && hit_status;
  wire flush_req = wr_status && reg_wdata[BIT_FLUSH];
  wire over_threshold = queue_level > {4'h0, queue_level_threshold};
  wire over_rise = over_threshold && !over_threshold_q;
  wire level_changed = queue_level != level_seen;
  wire [7:0] sources;
  wire [7:0] pending;

  // Sources in status bit order; the mask uses the same order.
  assign sources[BIT_NEAR_ENTER_FIRST] = near_enter_first; // see R1
  assign sources[BIT_NEAR_LEAVE_FIRST] = near_leave_first;
  assign sources[BIT_NEAR_ENTER_SECOND] = near_enter_second;
  assign sources[BIT_NEAR_LEAVE_SECOND] = near_leave_second;
  assign sources[BIT_GESTURE] = gesture_event;
  assign sources[BIT_SAMPLE] = sample_event;
  assign sources[BIT_WATCHDOG] = watchdog_event;
  // Edge of the comparison, so a clear holds while the level stays high.
  assign sources[BIT_QUEUE_LEVEL] = over_rise; // see R4

  assign evt.set_bits = sources;
  assign evt.clear_bits = wr_status ? reg_wdata[7:0] : 8'h00; // see R2, R10
  assign evt.read_clear = rd_status; // see R3

  assign pending = evt.status & ~event_mask; // see R5, R11
  assign irq = (|pending) || (addr_match_irq_en && slave_status[BIT_ADDR_MATCH]); // see R11, R8
  assign queue_flush = ce && flush_req; // see R7

  always_comb
  begin
    next_rdata = 16'h0000;
    if (hit_mask)
      next_rdata = {8'h00, event_mask};
    else if (hit_status)
      next_rdata = {queue_count, evt.status}; // see R6
    else if (hit_slave)
      next_rdata = slave_status; // see R8
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      event_mask <= MASK_RESET; // see R9
    else if (ce && wr_mask)
      event_mask <= reg_wdata[7:0];
  end

  // The count follows level changes; a read zeroes it and a flush clears bits 6 to 0, until the level moves again.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      queue_count <= COUNT_RESET;
    else if (ce)
    begin
      if (rd_status)
        queue_count <= COUNT_RESET; // see R3
      else if (flush_req)
        queue_count <= {queue_count[7], 7'h00}; // see R7
      else if (level_changed)
        queue_count <= queue_level; // see R6
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      level_seen <= COUNT_RESET;
      over_threshold_q <= 1'b0;
      slave_status <= SLAVE_RESET;
    end
    else if (ce)
    begin
      level_seen <= queue_level;
      over_threshold_q <= over_threshold;
      slave_status <= slave_status_in & SLAVE_READ_MASK; // see R8
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      reg_rvalid <= reg_read;
      if (reg_read)
        reg_rdata <= next_rdata;
    end
  end
endmodule

// ===== design/sism_event_if.sv
`timescale 1ns/1ns
interface sism_event_if;
  logic [7:0] set_bits;
  logic [7:0] clear_bits;
  logic read_clear;
  logic [7:0] status;
  modport core
  (
    output set_bits,
    output clear_bits,
    output read_clear,
    input status
  );
  modport latch
  (
    input set_bits,
    input clear_bits,
    input read_clear,
    output status
  );
endinterface

// ===== design/sism_event_latch.sv
`timescale 1ns/1ns
module sism_event_latch
  import sism_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Event traffic from the register core.
  sism_event_if.latch evt
);
  logic [7:0] flags;
  logic [7:0] next_flags;

  // A set arriving with a clear or a read wins, so no event is ever lost.
  assign next_flags = ((evt.read_clear ? 8'h00 : (flags & ~evt.clear_bits))) | evt.set_bits;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags <= STATUS_RESET;
    else if (ce)
      flags <= next_flags;
  end

  assign evt.status = flags;
endmodule

// ===== design/sism_pkg.sv
package sism_pkg;
  localparam int unsigned EVENT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 16;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h48;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h49;
  localparam logic [7:0] ADDR_SLAVE_STATUS = 8'h4A;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [15:0] SLAVE_RESET = 16'h0000;
  localparam int unsigned BIT_NEAR_ENTER_FIRST = 0;
  localparam int unsigned BIT_NEAR_LEAVE_FIRST = 1;
  localparam int unsigned BIT_NEAR_ENTER_SECOND = 2;
  localparam int unsigned BIT_NEAR_LEAVE_SECOND = 3;
  localparam int unsigned BIT_GESTURE = 4;
  localparam int unsigned BIT_SAMPLE = 5;
  localparam int unsigned BIT_WATCHDOG = 6;
  localparam int unsigned BIT_QUEUE_LEVEL = 7;
  localparam int unsigned BIT_FLUSH = 15;
  localparam int unsigned BIT_ADDR_MATCH = 0;
  localparam int unsigned FLUSH_CLEAR_BITS = 7;
  localparam logic [15:0] SLAVE_READ_MASK = 16'h07F7;
endpackage

// ===== testbench/sism_core_asserts.sv
`timescale 1ns/1ns
module sism_core_asserts
  import sism_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic queue_flush,
  input wire logic [7:0] queue_level,
  input wire logic [15:0] slave_status_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire rd = ce && reg_read;
  wire rd_st = rd && reg_addr == ADDR_EVENT_STATUS;
  wire fl = ce && reg_write && reg_addr == ADDR_EVENT_STATUS && reg_wdata[BIT_FLUSH];
  wire wr_mask = ce && reg_write && reg_addr == ADDR_EVENT_MASK;
  rvalid_after_read_a: assert property (rd |=> reg_rvalid) else $error("rvalid missing");
  rvalid_only_read_a: assert property (!rd |=> !reg_rvalid) else $error("rvalid stray");
  flush_strobe_a: assert property (queue_flush == fl) else $error("flush strobe");
  slave_read_a: assert property (rd && $past(ce) && reg_addr == ADDR_SLAVE_STATUS |=>
    reg_rdata == ($past(slave_status_in, 2) & SLAVE_READ_MASK)) else $error("slave status");
  mask_upper_zero_a: assert property (rd && reg_addr == ADDR_EVENT_MASK |=> reg_rdata[15:8] == 8'h00)
    else $error("mask upper");
  mask_write_read_a: assert property (wr_mask ##1 !wr_mask ##1 rd && reg_addr == ADDR_EVENT_MASK |=>
    reg_rdata[7:0] == $past(reg_wdata[7:0], 3)) else $error("mask value");
  // Level held steady so a late count update cannot race the clear.
  flush_count_a: assert property (fl && $stable(queue_level) ##1 $stable(queue_level) ##1
    rd_st && $stable(queue_level) |=> reg_rdata[14:8] == 7'h00) else $error("flush count");
  read_clear_a: assert property (rd_st && $stable(queue_level) ##1 $stable(queue_level) ##1
    rd_st && $stable(queue_level) |=> reg_rdata[15:8] == 8'h00) else $error("read clear");
  cover property (fl);
  cover property (rd_st);
  cover property (rd && reg_addr == ADDR_SLAVE_STATUS);
endmodule
bind sism_core sism_core_asserts sism_core_asserts_i (.*);

// ===== testbench/sism_host.sv
`timescale 1ns/1ns
module sism_host
(
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr = 8'h00,
  output logic [15:0] reg_wdata = 16'h0000,
  output logic reg_write = 1'b0,
  output logic reg_read = 1'b0
);
  int timeouts = 0;
  // Flags are acknowledged by writing ones; bit 15 clears queue count bits 6 to 0.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int i;
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    for (i = 0; i < 4; i++)
    begin
      @(negedge clk);
      if (reg_rvalid === 1'b1)
        break;
    end
    if (i == 4)
      timeouts++;
    d = reg_rdata;
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ns
module testbench
  import sism_pkg::*;
;
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; $display("BAD %s %h %h", n, e, a); end end
  logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, addr_match_irq_en = 1'b0;
  logic [6:0] evt = 7'h00;
  logic [7:0] queue_level = 8'h00, reg_addr;
  logic [3:0] queue_level_threshold = 4'h0;
  logic [15:0] slave_status_in = 16'h0000, reg_wdata, reg_rdata, d;
  logic reg_write, reg_read, reg_rvalid, queue_flush, irq;
  int miscompares = 0;
  int num_checks = 0;
  initial forever #5 clk = ~clk;
  sism_host sism_host_i (.*);
  sism_core sism_core_i (.*, .near_enter_first(evt[0]), .near_leave_first(evt[1]), .near_enter_second(evt[2]),
    .near_leave_second(evt[3]), .gesture_event(evt[4]), .sample_event(evt[5]), .watchdog_event(evt[6]));
  task automatic finish_test;
    miscompares += sism_host_i.timeouts;
    $display("checks %0d bad %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    evt <= 7'h01 << i;
    @(posedge clk);
    evt <= 7'h00;
    @(negedge clk);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    ce <= 1'b0;
    sism_host_i.wr(ADDR_EVENT_MASK, 16'h0000);
    ce <= 1'b1;
    sism_host_i.rd(ADDR_EVENT_MASK, d);
    `CHK("mask", {8'h00, MASK_RESET}, d)
    sism_host_i.rd(ADDR_EVENT_STATUS, d);
    `CHK("status", 16'h0000, d)
    $display("reset test done");
    for (int i = 0; i < 7; i++)
    begin
      pulse(i);
      sism_host_i.rd(ADDR_EVENT_STATUS, d);
      `CHK("flag", 16'h0001 << i, d)
      sism_host_i.rd(ADDR_EVENT_STATUS, d);
      `CHK("clear", 16'h0000, d)
    end
    $display("event test done");
    sism_host_i.wr(ADDR_EVENT_MASK, 16'h00FE);
    pulse(1);
    `CHK("irq masked", 1'b0, irq)
    pulse(0);
    `CHK("irq", 1'b1, irq)
    sism_host_i.wr(ADDR_EVENT_STATUS, 16'h0002);
    @(negedge clk);
    `CHK("irq held", 1'b1, irq)
    sism_host_i.wr(ADDR_EVENT_STATUS, 16'h0001);
    @(negedge clk);
    `CHK("irq low", 1'b0, irq)
    sism_host_i.wr(ADDR_EVENT_MASK, 16'hA55A);
    sism_host_i.rd(ADDR_EVENT_MASK, d);
    `CHK("mask rw", 16'h005A, d)
    $display("mask test done");
    @(posedge clk);
    queue_level_threshold <= 4'h4;
    queue_level <= 8'h05;
    repeat (3) @(posedge clk);
    sism_host_i.rd(ADDR_EVENT_STATUS, d);
    `CHK("queue", 16'h0580, d)
    @(posedge clk);
    queue_level <= 8'h89;
    repeat (3) @(posedge clk);
    sism_host_i.wr(ADDR_EVENT_STATUS, 16'h8000);
    sism_host_i.rd(ADDR_EVENT_STATUS, d);
    `CHK("flush", 16'h8000, d)
    $display("queue test done");
    @(posedge clk);
    slave_status_in <= 16'hFFFF;
    sism_host_i.wr(ADDR_SLAVE_STATUS, 16'h0000);
    sism_host_i.rd(ADDR_SLAVE_STATUS, d);
    `CHK("slave", SLAVE_READ_MASK, d)
    `CHK("no route", 1'b0, irq)
    @(posedge clk);
    addr_match_irq_en <= 1'b1;
    @(negedge clk);
    `CHK("route", 1'b1, irq)
    sism_host_i.rd(8'h50, d);
    `CHK("unmapped", 16'h0000, d)
    $display("slave test done");
    finish_test;
  end
endmodule
